// ---- ssd_pkg.sv ----
// package with offsets, field layouts, opcodes and reset values of the decoder
package ssd_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_INSN = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DIR = 8'h0C;
  localparam logic [7:0] OFF_FADDR = 8'h10;
  localparam logic [7:0] OFF_FDATA = 8'h14;
  // instruction word fields
  localparam int INSN_W = 12;
  localparam int DEST_BIT = 5;
  localparam int ADDR_W = 5;
  localparam logic [5:0] OP_MINUS = 6'h02;
  localparam logic [5:0] OP_SWAP = 6'h0E;
  localparam logic [11:0] OP_DIR_LOAD = 12'h006;
  // status layout
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam int REG_DEPTH = 32;
endpackage

// ---- ssd_alu.sv ----
// combinational datapath: subtract, nibble exchange and flags
`timescale 1ns/1ps
module ssd_alu (
  input wire logic [7:0] file_val,
  input wire logic [7:0] acc_val,
  output logic [7:0] diff,
  output logic [7:0] swapped,
  output logic carry,
  output logic half_borrow_flag,
  output logic zero
);
  logic [8:0] wide;
  logic [4:0] low;
  // two's complement subtract, carry high when no borrow
  always_comb begin
    wide = {1'b0, file_val} + {1'b0, ~acc_val} + 9'h001; // [RQ1]
    low = {1'b0, file_val[3:0]} + {1'b0, ~acc_val[3:0]} + 5'h01;
    diff = wide[7:0];
    carry = wide[8]; // [RQ2]
    half_borrow_flag = low[4]; // [RQ2]
    zero = (wide[7:0] == 8'h00); // [RQ2]
    swapped = {file_val[3:0], file_val[7:4]}; // [RQ3]
  end
endmodule

// ---- ssd_top.sv ----
// apb-driven executor for subtract, nibble exchange and direction load
// Overview of operation
// RQ1 - subtract acc from file, dest bit picks
// RQ2 - subtract sets carry, half borrow, zero
// RQ3 - exchange nibbles, flags untouched
// RQ4 - exchange with dest 0 writes accumulator only
// RQ5 - exchange with dest 1 writes file register
// RQ6 - direction load copies acc, one cycle
`timescale 1ns/1ps
module ssd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] pin_dir
);
  typedef struct packed {
    logic [7:0] acc;
    logic [2:0] status;
    logic [7:0] dir;
    logic [4:0] faddr;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } ssd_state_t;

  ssd_state_t s_reg;
  ssd_state_t s_next;
  logic [7:0] file_mem [ssd_pkg::REG_DEPTH];
  logic [7:0] diff;
  logic [7:0] swapped;
  logic carry;
  logic half_b;
  logic zero;
  logic wr_acc;
  logic wr_file;
  logic [7:0] file_wdata;
  logic [4:0] file_waddr;
  logic [11:0] insn;
  logic [7:0] fval;
  logic setup;
  logic access;
  logic ins_wr;
  logic is_minus;
  logic is_swap;
  logic is_dir;

  assign setup = psel && !penable;
  // completing access edge: the one edge at which a write takes effect
  assign access = psel && penable && s_reg.ready;
  assign ins_wr = access && pwrite && paddr == ssd_pkg::OFF_INSN;
  assign insn = pwdata[11:0];
  assign fval = file_mem[insn[4:0]];
  assign is_minus = insn[11:6] == ssd_pkg::OP_MINUS;
  assign is_swap = insn[11:6] == ssd_pkg::OP_SWAP;
  assign is_dir = insn == ssd_pkg::OP_DIR_LOAD;

  ssd_alu u_alu (
    .file_val(fval),
    .acc_val(s_reg.acc),
    .diff(diff),
    .swapped(swapped),
    .carry(carry),
    .half_borrow_flag(half_b),
    .zero(zero)
  );

  // apb decode: answer, read data and refusal registered in the setup cycle,
  // writes and instructions applied at the completing access edge
  always_comb begin
    s_next = s_reg;
    s_next.ready = 1'b0;
    s_next.err = 1'b0;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    file_wdata = 8'h00;
    file_waddr = 5'h00;
    if (access && pwrite) begin
      case (paddr)
        ssd_pkg::OFF_INSN: begin
          if (is_minus) begin
            s_next.status[ssd_pkg::ST_CARRY] = carry; // [RQ2]
            s_next.status[ssd_pkg::ST_HALF] = half_b; // [RQ2]
            s_next.status[ssd_pkg::ST_ZERO] = zero; // [RQ2]
            wr_acc = !insn[ssd_pkg::DEST_BIT]; // [RQ1]
            wr_file = insn[ssd_pkg::DEST_BIT]; // [RQ1]
            file_wdata = diff;
          end else if (is_swap) begin
            wr_acc = !insn[ssd_pkg::DEST_BIT]; // [RQ4]
            wr_file = insn[ssd_pkg::DEST_BIT]; // [RQ5]
            file_wdata = swapped; // [RQ3]
          end else if (is_dir) begin
            s_next.dir = s_reg.acc; // [RQ6]
          end
          file_waddr = insn[4:0];
          if (wr_acc) begin
            s_next.acc = file_wdata;
          end
        end
        ssd_pkg::OFF_ACC: s_next.acc = pwdata[7:0];
        ssd_pkg::OFF_STATUS: s_next.status = pwdata[2:0];
        ssd_pkg::OFF_FADDR: s_next.faddr = pwdata[4:0];
        ssd_pkg::OFF_FDATA: begin
          wr_file = 1'b1;
          file_waddr = s_reg.faddr;
          file_wdata = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
    if (setup) begin
      s_next.ready = 1'b1;
      s_next.rdata = 32'h0000_0000;
      if (pwrite) begin
        case (paddr)
          ssd_pkg::OFF_INSN: s_next.err = !(is_minus || is_swap || is_dir); // other opcodes
          ssd_pkg::OFF_ACC: s_next.err = 1'b0;
          ssd_pkg::OFF_STATUS: s_next.err = 1'b0;
          ssd_pkg::OFF_FADDR: s_next.err = 1'b0;
          ssd_pkg::OFF_FDATA: s_next.err = 1'b0;
          default: s_next.err = 1'b1;
        endcase
      end else begin
        case (paddr)
          ssd_pkg::OFF_INSN: s_next.rdata = 32'h0000_0000;
          ssd_pkg::OFF_ACC: s_next.rdata = {24'h000000, s_reg.acc};
          ssd_pkg::OFF_STATUS: s_next.rdata = {29'h0000_0000, s_reg.status};
          ssd_pkg::OFF_DIR: s_next.rdata = {24'h000000, s_reg.dir};
          ssd_pkg::OFF_FADDR: s_next.rdata = {27'h0000_0000, s_reg.faddr};
          ssd_pkg::OFF_FDATA: s_next.rdata = {24'h000000, file_mem[s_reg.faddr]};
          default: s_next.err = 1'b1;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{acc: ssd_pkg::ACC_RST, status: ssd_pkg::STATUS_RST,
                 dir: ssd_pkg::DIR_RST, faddr: 5'h00, rdata: 32'h0000_0000,
                 ready: 1'b0, err: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // file register array, no reset
  always_ff @(posedge pclk) begin
    if (wr_file) begin
      file_mem[file_waddr] <= file_wdata;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign pin_dir = s_reg.dir;

  property p_dir_load;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_dir) |=> pin_dir == $past(s_reg.acc);
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction load wrong"); // [RQ6]

  property p_dir_flags;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_dir) |=> $stable(s_reg.status) && $stable(s_reg.acc);
  endproperty
  a_dir_flags: assert property (p_dir_flags) else $error("direction load changed state"); // [RQ6]

  property p_sub_acc;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_minus && !insn[ssd_pkg::DEST_BIT])
      |=> s_reg.acc == 8'($past(fval) - $past(s_reg.acc));
  endproperty
  a_sub_acc: assert property (p_sub_acc) else $error("subtract result wrong"); // [RQ1]

  property p_sub_carry;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_minus)
      |=> s_reg.status[ssd_pkg::ST_CARRY] == ($past(fval) >= $past(s_reg.acc))
        && s_reg.status[ssd_pkg::ST_HALF] == ($past(fval[3:0]) >= $past(s_reg.acc[3:0]));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("carry or half borrow wrong"); // [RQ2]

  property p_swap_flags;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_swap) |=> $stable(s_reg.status);
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap changed flags"); // [RQ3]

  property p_swap_acc;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_swap && !insn[ssd_pkg::DEST_BIT])
      |=> s_reg.acc == {$past(fval[3:0]), $past(fval[7:4])};
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong"); // [RQ4]

  property p_swap_file;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_swap && insn[ssd_pkg::DEST_BIT])
      |=> file_mem[$past(insn[4:0])] == {$past(fval[3:0]), $past(fval[7:4])}
        && $stable(s_reg.acc);
  endproperty
  a_swap_file: assert property (p_swap_file) else $error("swap to file wrong"); // [RQ5]

  property p_sub_file;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_minus && insn[ssd_pkg::DEST_BIT])
      |=> $stable(s_reg.acc)
        && file_mem[$past(insn[4:0])] == 8'($past(fval) - $past(s_reg.acc));
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("subtract to file wrong"); // [RQ1]

  property p_zero;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_minus)
      |=> s_reg.status[ssd_pkg::ST_ZERO] == ($past(fval) == $past(s_reg.acc));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RQ2]

  // unknown instruction word is refused and leaves state alone
  property p_bad_insn;
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && !is_minus && !is_swap && !is_dir)
      |=> $stable(s_reg.acc) && $stable(s_reg.dir) && $stable(s_reg.status);
  endproperty
  a_bad_insn: assert property (p_bad_insn) else $error("refused instruction had effect");

  c_sub: cover property (@(posedge pclk) ins_wr && is_minus);
  c_swap: cover property (@(posedge pclk) ins_wr && is_swap);
  c_dir: cover property (@(posedge pclk) ins_wr && is_dir);
endmodule

// ---- ssd_top_tb.sv ----
// self-checking apb testbench for the subtract, swap and direction-load executor
`timescale 1ns/1ps
module ssd_top_tb;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin_dir;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  ssd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_dir(pin_dir));

  // free-running clock, 20 ns period
  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e}, "read");
  endtask

  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // preload file slot, accumulator and status, then run one instruction
  task automatic run(input logic [7:0] f, input logic [7:0] a, input logic [2:0] s,
                     input logic [11:0] insn);
    apb(1'b1, ssd_pkg::OFF_FADDR, {27'h0, insn[4:0]});
    apb(1'b1, ssd_pkg::OFF_FDATA, {24'h0, f});
    apb(1'b1, ssd_pkg::OFF_ACC, {24'h0, a});
    apb(1'b1, ssd_pkg::OFF_STATUS, {29'h0, s});
    apb(1'b1, ssd_pkg::OFF_INSN, {20'h0, insn});
    chk({31'h0, err}, 32'h0, "insn refused");
  endtask

  task automatic sub(input logic [7:0] f, input logic [7:0] a, input logic d);
    logic [7:0] df;
    logic [2:0] st;
    df = f - a;
    st = 3'h0;
    st[ssd_pkg::ST_CARRY] = (f >= a);
    st[ssd_pkg::ST_HALF] = (f[3:0] >= a[3:0]);
    st[ssd_pkg::ST_ZERO] = (df == 8'h00);
    run(f, a, ~st, {ssd_pkg::OP_MINUS, d, 5'h03});
    rdc(ssd_pkg::OFF_ACC, d ? a : df);
    rdc(ssd_pkg::OFF_FDATA, d ? df : f);
    rdc(ssd_pkg::OFF_STATUS, {5'h0, st});
    idle();
    $display("subtract %h - %h dest %0d done", f, a, d);
  endtask

  task automatic swp(input logic [7:0] f, input logic d);
    run(f, 8'h33, 3'h5, {ssd_pkg::OP_SWAP, d, 5'h07});
    rdc(ssd_pkg::OFF_ACC, d ? 8'h33 : {f[3:0], f[7:4]});
    rdc(ssd_pkg::OFF_FDATA, d ? {f[3:0], f[7:4]} : f);
    rdc(ssd_pkg::OFF_STATUS, 8'h05);
    idle();
    $display("swap %h dest %0d done", f, d);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({24'h0, pin_dir}, 32'hFF, "direction reset");
    rdc(ssd_pkg::OFF_ACC, 8'h00);
    idle();
    $display("reset values done");
    sub(8'h03, 8'h02, 1'b1);
    sub(8'h02, 8'h02, 1'b1);
    sub(8'h01, 8'h02, 1'b1);
    sub(8'h10, 8'h01, 1'b0);
    swp(8'hA5, 1'b0);
    swp(8'h3C, 1'b1);
    // direction load copies the accumulator, flags kept
    run(8'h00, 8'hA5, 3'h2, ssd_pkg::OP_DIR_LOAD);
    rdc(ssd_pkg::OFF_DIR, 8'hA5);
    chk({24'h0, pin_dir}, 32'hA5, "direction");
    rdc(ssd_pkg::OFF_STATUS, 8'h02);
    rdc(ssd_pkg::OFF_ACC, 8'hA5);
    rdc(ssd_pkg::OFF_INSN, 8'h00);
    rdc(ssd_pkg::OFF_FADDR, 8'h06);
    // unknown opcode, direction register write and unmapped address are refused
    apb(1'b1, ssd_pkg::OFF_ACC, 32'h5A);
    apb(1'b1, ssd_pkg::OFF_INSN, 32'h007);
    chk({31'h0, err}, 32'h1, "bad opcode");
    rdc(ssd_pkg::OFF_ACC, 8'h5A);
    apb(1'b1, ssd_pkg::OFF_DIR, 32'h11);
    chk({31'h0, err}, 32'h1, "direction write");
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    chk({24'h0, pin_dir}, 32'hA5, "direction kept");
    idle();
    $display("direction load and refusals done");
    end_sim();
  end
endmodule
